// ==== rtl/irq_ctrl_pkg.sv ====
// Shared constants for the nested interrupt pending and priority logic.
package irq_ctrl_pkg;

  // Documented sizes: interrupt count and width of one priority field.
  localparam int DEF_NUM_IRQ = 36;
  localparam int PRIO_W = 3;
  localparam int ID_W = 6;

  // APB register byte offsets.
  localparam logic [7:0] OFF_SET_SET_PENDING_BANK_ZERO = 8'h00;
  localparam logic [7:0] OFF_SET_PEND1 = 8'h04;
  localparam logic [7:0] OFF_CLR_SET_PENDING_BANK_ZERO = 8'h08;
  localparam logic [7:0] OFF_CLR_PEND1 = 8'h0C;
  localparam logic [7:0] OFF_ACTIVE0 = 8'h10;
  localparam logic [7:0] OFF_ACTIVE1 = 8'h14;
  localparam logic [7:0] OFF_MODE0 = 8'h18;
  localparam logic [7:0] OFF_MODE1 = 8'h1C;
  localparam logic [7:0] OFF_PRIO0 = 8'h20;
  localparam logic [7:0] OFF_SW_TRIG = 8'h40;
  localparam logic [7:0] OFF_GROUPING = 8'h44;
  localparam logic [7:0] OFF_REQ_STATUS = 8'h48;
  localparam logic [7:0] OFF_INT_STATUS = 8'h4C;
  localparam logic [7:0] OFF_INT_MASK = 8'h50;

  // Register layout figures.
  localparam int BANK_W = 32;
  localparam int PRIO_PER_WORD = 8;
  localparam int PRIO_NIBBLE = 4;
  localparam int WORD_BYTES = 4;
  localparam int SUB_W = 2;
  localparam int REQ_VALID_LSB = 0;
  localparam int REQ_ID_LSB = 8;
  localparam int REQ_PRIO_LSB = 16;
  localparam int REQ_GROUP_LSB = 20;
  localparam int REQ_SUB_LSB = 24;

  // Event bits of the interrupt status and mask registers.
  localparam int EVT_W = 2;
  localparam int EVT_NMI = 0;
  localparam int EVT_REQ = 1;

  // Reset values.
  localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;
  localparam logic [SUB_W-1:0] SUB_RESET = 2'h0;
  localparam logic [EVT_W-1:0] MASK_RESET = 2'h0;
  localparam logic [PRIO_W-1:0] PRIO_LEAST = 3'h7;

endpackage : irq_ctrl_pkg

// ==== rtl/nested_vectored_irq_ctrl.sv ====
// Pending, active and priority logic of the nested vectored interrupt controller with an APB register port.
//
// Behaviour
// R1: Thirty-six interrupt inputs, each with a programmable priority from 0 to 7.
// R2: Lower priority number is more urgent; level 0 wins.
// R3: Priority splits into group priority and subpriority by a programmable grouping.
// R4: Priority may be rewritten at run time; next arbitration uses the new level.
// R5: One external non-maskable input is accepted besides the peripheral interrupts.
// R6: Pulse inputs are sampled on the rising clock edge and detected pulses latched.
// R7: A pulse source holds its line high at least one clock cycle.
// R8: A level source holds its line high until it no longer needs service.
// R9: Input seen high while the interrupt is not active makes it pending.
// R10: A rising edge on an input makes that interrupt pending.
// R11: Software set-pending bit or trigger register naming the interrupt makes it pending.
// R12: Service routine entry clears pending and marks the interrupt active.
// R13: Level interrupt return resamples input: high gives pending, low gives inactive.
// R14: A pulse during an active pulse interrupt makes it pending and active.
// R15: Pulse interrupt returning while pending stays pending for immediate re-entry.
// R16: Pulse interrupt without new pulse during its routine returns to inactive.
// R17: Clear-pending on level interrupt: no change if input high, else inactive.
// R18: Clear-pending on pulse interrupt: pending to inactive, active-and-pending to active.
// R19: Most urgent pending interrupt is presented; ties go to the lower number.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

module nested_vectored_irq_ctrl
  import irq_ctrl_pkg::*;
#(
  parameter int NUM_IRQ = DEF_NUM_IRQ
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_IRQ-1:0] irq_line,
  input wire logic nmi_pin,
  input wire logic isr_enter,
  input wire logic [ID_W-1:0] isr_enter_id,
  input wire logic isr_return,
  input wire logic [ID_W-1:0] isr_return_id,
  output logic req_valid,
  output logic [ID_W-1:0] req_id,
  output logic [PRIO_W-1:0] req_prio,
  output logic [PRIO_W-1:0] req_group,
  output logic [PRIO_W-1:0] req_sub,
  output logic nmi_req,
  output logic [NUM_IRQ-1:0] pending,
  output logic [NUM_IRQ-1:0] active,
  output logic irq_out
);

  localparam int PRIO_WORDS = (NUM_IRQ + PRIO_PER_WORD - 1) / PRIO_PER_WORD;

  // Whole state of the block, registered by one process.
  typedef struct packed {
    logic [NUM_IRQ-1:0] pend;
    logic [NUM_IRQ-1:0] act;
    logic [NUM_IRQ-1:0] pulse_mode;
    logic [NUM_IRQ-1:0] last_in;
    logic [NUM_IRQ*PRIO_W-1:0] prio;
    logic [SUB_W-1:0] sub_bits;
    logic [EVT_W-1:0] evt_stat;
    logic [EVT_W-1:0] evt_mask;
    logic nmi_s1;
    logic nmi_s2;
    logic nmi_prev;
    logic req_valid;
    logic [ID_W-1:0] req_id;
    logic [PRIO_W-1:0] req_prio;
    logic [PRIO_W-1:0] req_group;
    logic [PRIO_W-1:0] req_sub;
    logic [31:0] prdata;
    logic pslverr;
  } state_t;

  state_t s;
  state_t next_s;

  // Combinational next-state logic for bus, interrupt state and arbitration.
  always_comb
  begin
    logic setup;
    logic wr;
    logic hit;
    logic in_hi;
    logic rise;
    logic enter;
    logic ret;
    logic found;
    logic [63:0] set_wide;
    logic [63:0] clr_wide;
    logic [NUM_IRQ-1:0] set_sw;
    logic [NUM_IRQ-1:0] clr_sw;
    logic [PRIO_W-1:0] best_p;
    logic [ID_W-1:0] best_i;
    logic [31:0] rd;
    logic [EVT_W-1:0] evt_set;
    // Every field holds its value unless a branch below changes it.
    next_s = s;
    setup = psel && !penable;
    wr = psel && penable && pwrite;
    hit = 1'b0;
    rd = 32'h0000_0000;
    set_wide = 64'h0;
    clr_wide = 64'h0;
    found = 1'b0;
    best_p = PRIO_LEAST;
    best_i = '0;
    evt_set = '0;
    in_hi = 1'b0;
    rise = 1'b0;
    enter = 1'b0;
    ret = 1'b0;
    set_sw = '0;
    clr_sw = '0;

    // Read data and error flag are captured in the setup cycle.
    unique case (paddr)
      OFF_SET_SET_PENDING_BANK_ZERO, OFF_CLR_SET_PENDING_BANK_ZERO:
      begin
        hit = 1'b1;
        rd = 32'(s.pend);
      end
      OFF_SET_PEND1, OFF_CLR_PEND1:
      begin
        hit = 1'b1;
        rd = 32'(64'(s.pend) >> BANK_W);
      end
      OFF_ACTIVE0:
      begin
        hit = 1'b1;
        rd = 32'(s.act);
      end
      OFF_ACTIVE1:
      begin
        hit = 1'b1;
        rd = 32'(64'(s.act) >> BANK_W);
      end
      OFF_MODE0:
      begin
        hit = 1'b1;
        rd = 32'(s.pulse_mode);
      end
      OFF_MODE1:
      begin
        hit = 1'b1;
        rd = 32'(64'(s.pulse_mode) >> BANK_W);
      end
      OFF_SW_TRIG:
      begin
        hit = 1'b1;
      end
      OFF_GROUPING:
      begin
        hit = 1'b1;
        rd = 32'(s.sub_bits);
      end
      OFF_REQ_STATUS:
      begin
        hit = 1'b1;
        rd[REQ_VALID_LSB] = s.req_valid;
        rd[REQ_ID_LSB +: ID_W] = s.req_id;
        rd[REQ_PRIO_LSB +: PRIO_W] = s.req_prio;
        rd[REQ_GROUP_LSB +: PRIO_W] = s.req_group;
        rd[REQ_SUB_LSB +: PRIO_W] = s.req_sub;
      end
      OFF_INT_STATUS:
      begin
        hit = 1'b1;
        rd = 32'(s.evt_stat);
      end
      OFF_INT_MASK:
      begin
        hit = 1'b1;
        rd = 32'(s.evt_mask);
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase

    // Priority words hold eight 3-bit fields, one per nibble.
    for (int k = 0; k < PRIO_WORDS; k++)
    begin
      if (paddr == 8'(OFF_PRIO0 + k * WORD_BYTES))
      begin
        hit = 1'b1;
        for (int j = 0; j < PRIO_PER_WORD; j++)
        begin
          if (k * PRIO_PER_WORD + j < NUM_IRQ)
          begin
            rd[j*PRIO_NIBBLE +: PRIO_W] = s.prio[(k*PRIO_PER_WORD+j)*PRIO_W +: PRIO_W];
          end
        end
      end
    end

    // Capturing in the setup cycle keeps read data steady through the access phase.
    if (setup)
    begin
      next_s.prdata = pwrite ? 32'h0000_0000 : rd;
      next_s.pslverr = !hit;
    end

    // Register writes take effect at the access edge; pready is always high.
    if (wr)
    begin
      unique case (paddr)
        OFF_SET_SET_PENDING_BANK_ZERO: set_wide[BANK_W-1:0] = pwdata; // R11
        OFF_SET_PEND1: set_wide[2*BANK_W-1:BANK_W] = pwdata; // R11
        OFF_CLR_SET_PENDING_BANK_ZERO: clr_wide[BANK_W-1:0] = pwdata;
        OFF_CLR_PEND1: clr_wide[2*BANK_W-1:BANK_W] = pwdata;
        OFF_MODE0: next_s.pulse_mode = NUM_IRQ'({32'(64'(s.pulse_mode) >> BANK_W), pwdata});
        OFF_MODE1: next_s.pulse_mode = NUM_IRQ'({pwdata, 32'(s.pulse_mode)});
        OFF_SW_TRIG:
        begin
          if (32'(pwdata[ID_W-1:0]) < NUM_IRQ)
          begin
            set_wide[pwdata[ID_W-1:0]] = 1'b1; // R11
          end
        end
        OFF_GROUPING: next_s.sub_bits = pwdata[SUB_W-1:0]; // R3
        OFF_INT_MASK: next_s.evt_mask = pwdata[EVT_W-1:0];
        default:
        begin
        end
      endcase
      // Priority fields change in place; the next arbitration already uses them.
      for (int k = 0; k < PRIO_WORDS; k++)
      begin
        if (paddr == 8'(OFF_PRIO0 + k * WORD_BYTES))
        begin
          for (int j = 0; j < PRIO_PER_WORD; j++)
          begin
            if (k * PRIO_PER_WORD + j < NUM_IRQ)
            begin
              next_s.prio[(k*PRIO_PER_WORD+j)*PRIO_W +: PRIO_W] = pwdata[j*PRIO_NIBBLE +: PRIO_W]; // R1 R4
            end
          end
        end
      end
    end

    // Bits above the implemented interrupts are dropped, so unknown numbers do nothing.
    set_sw = set_wide[NUM_IRQ-1:0];
    clr_sw = clr_wide[NUM_IRQ-1:0];

    // Per-interrupt state: exits and clears first, then sets, so a set wins.
    for (int i = 0; i < NUM_IRQ; i++)
    begin
      // Request lines share the clock, so they are used without synchronising.
      in_hi = irq_line[i];
      rise = in_hi && !s.last_in[i]; // R6
      enter = isr_enter && (isr_enter_id == ID_W'(i));
      ret = isr_return && (isr_return_id == ID_W'(i));
      next_s.last_in[i] = in_hi; // R6
      // Routine entry moves the interrupt from pending to active.
      if (enter)
      begin
        next_s.pend[i] = 1'b0; // R12
        next_s.act[i] = 1'b1; // R12
      end
      // Return ends activity; a level source is resampled, a pulse keeps its pending bit.
      if (ret)
      begin
        next_s.act[i] = 1'b0; // R16
        if (!s.pulse_mode[i])
        begin
          next_s.pend[i] = in_hi; // R13
        end
      end
      // A level source that still asserts its line ignores a clear-pending write.
      if (clr_sw[i])
      begin
        if (s.pulse_mode[i])
        begin
          next_s.pend[i] = 1'b0; // R18
        end
        else if (!in_hi)
        begin
          next_s.pend[i] = 1'b0; // R17
          next_s.act[i] = 1'b0; // R17
        end
      end
      // A high level pends only while the interrupt is not being served.
      if (!s.pulse_mode[i] && in_hi && !next_s.act[i])
      begin
        next_s.pend[i] = 1'b1; // R9
      end
      // A new pulse pends even during its own routine, so it is never lost.
      if (s.pulse_mode[i] && rise)
      begin
        next_s.pend[i] = 1'b1; // R10 R14 R15
      end
      // Software sets come last so they win over a clear in the same cycle.
      if (set_sw[i])
      begin
        next_s.pend[i] = 1'b1; // R11
      end
    end

    // Strict compare keeps the lowest number among equal levels.
    for (int i = 0; i < NUM_IRQ; i++)
    begin
      if (s.pend[i] && (!found || s.prio[i*PRIO_W +: PRIO_W] < best_p)) // R2 R19
      begin
        found = 1'b1;
        best_p = s.prio[i*PRIO_W +: PRIO_W];
        best_i = ID_W'(i);
      end
    end
    // Request outputs are registered, one edge behind the pending vector.
    next_s.req_valid = found; // R19
    next_s.req_id = best_i; // R19
    next_s.req_prio = best_p;
    next_s.req_group = best_p >> s.sub_bits; // R3
    next_s.req_sub = best_p & PRIO_W'((4'h1 << s.sub_bits) - 4'h1); // R3

    // External non-maskable input passes two flip-flops before use.
    next_s.nmi_s1 = nmi_pin; // R5
    next_s.nmi_s2 = s.nmi_s1;
    next_s.nmi_prev = s.nmi_s2;

    // Event status: write one to clear, a new event in the same cycle wins.
    evt_set[EVT_NMI] = s.nmi_s2 && !s.nmi_prev; // R5
    evt_set[EVT_REQ] = found && !s.req_valid;
    if (wr && paddr == OFF_INT_STATUS)
    begin
      next_s.evt_stat = s.evt_stat & ~pwdata[EVT_W-1:0];
    end
    next_s.evt_stat = next_s.evt_stat | evt_set;
  end

  // State register with asynchronous active-low reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Request priority and group rest at the least urgent level until the first arbitration.
      s <= '0;
      s.prio <= {NUM_IRQ{PRIO_RESET}};
      s.sub_bits <= SUB_RESET;
      s.evt_mask <= MASK_RESET;
      s.req_prio <= PRIO_LEAST;
      s.req_group <= PRIO_LEAST;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs come from the state register; pready is tied high and irq_out gates event status with the mask.
  assign prdata = s.prdata;
  assign pready = 1'b1; // Zero wait states.
  assign pslverr = s.pslverr;
  assign req_valid = s.req_valid;
  assign req_id = s.req_id;
  assign req_prio = s.req_prio;
  assign req_group = s.req_group;
  assign req_sub = s.req_sub;
  assign nmi_req = s.nmi_s2; // R5
  assign pending = s.pend;
  assign active = s.act;
  assign irq_out = |(s.evt_stat & s.evt_mask);

endmodule : nested_vectored_irq_ctrl

// ==== sim/irq_ctrl_props.sv ====
// Port-level checks of the interrupt controller.
`timescale 1ns/1ps
module irq_ctrl_props
  import irq_ctrl_pkg::*;
#(
  parameter int NUM_IRQ = DEF_NUM_IRQ
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [NUM_IRQ-1:0] irq_line,
  input wire logic nmi_pin,
  input wire logic isr_enter,
  input wire logic [ID_W-1:0] isr_enter_id,
  input wire logic isr_return,
  input wire logic [ID_W-1:0] isr_return_id,
  input wire logic req_valid,
  input wire logic [ID_W-1:0] req_id,
  input wire logic [PRIO_W-1:0] req_prio,
  input wire logic [PRIO_W-1:0] req_group,
  input wire logic [PRIO_W-1:0] req_sub,
  input wire logic nmi_req,
  input wire logic [NUM_IRQ-1:0] pending,
  input wire logic [NUM_IRQ-1:0] active
);
  // All checks sample on the bus clock and rest during reset.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_ENTER:
  assert property (isr_enter && isr_enter_id < NUM_IRQ && !isr_return |=> active[$past(isr_enter_id)]) else $error("entry lost");
  AST_ACT_CAUSE:
  assert property ($rose(active[3]) |-> $past(isr_enter && isr_enter_id == 6'h03)) else $error("active without entry");
  AST_RISE:
  assert property ($rose(irq_line[3]) && !active[3] && !isr_enter |=> pending[3]) else $error("edge not latched");
  AST_PEND_CAUSE:
  assert property ($rose(pending[3]) |-> $past(irq_line[3] || (psel && penable && pwrite))) else $error("stray pending");
  AST_RETURN:
  assert property (isr_return && isr_return_id == 6'h03 && !irq_line[3] && !isr_enter |=> !active[3]) else $error("kept active");
  AST_REQ_VALID:
  assert property (req_valid == $past(|pending)) else $error("request flag wrong");
  AST_REQ_ID:
  assert property (req_valid |-> (($past(pending) >> req_id) & 1) != 0) else $error("request not pending");
  AST_NMI:
  assert property (nmi_pin [*3] |-> nmi_req) else $error("nmi not passed");
  AST_GROUP:
  assert property (req_valid |-> (req_group == req_prio && req_sub == 3'h0)
    || (req_group == (req_prio >> 1) && req_sub == (req_prio & 3'h1))
    || (req_group == (req_prio >> 2) && req_sub == (req_prio & 3'h3))
    || (req_group == 3'h0 && req_sub == req_prio)) else $error("group split wrong");
  // Main scenarios reached.
  COV_NMI: cover property (nmi_req);
  COV_PULSE: cover property (isr_return && pending[5] && active[5]);
  COV_REQ: cover property (req_valid && req_id == 6'h03);
endmodule : irq_ctrl_props

// ==== sim/irq_peer_model.sv ====
// Peripheral and core model driving the request side of the controller.
`timescale 1ns/1ps
module irq_peer_model
  import irq_ctrl_pkg::*;
(
  input wire logic pclk,
  output logic [DEF_NUM_IRQ-1:0] irq_line = '0,
  output logic nmi_pin = 1'b0,
  output logic isr_enter = 1'b0,
  output logic [ID_W-1:0] isr_enter_id = '0,
  output logic isr_return = 1'b0,
  output logic [ID_W-1:0] isr_return_id = '0
);
  // A level source keeps its line until it is served.
  task automatic level(input int n, input logic v);
    @(posedge pclk);
    irq_line[n] <= v;
    @(posedge pclk);
  endtask : level
  // A pulse source holds its line for one whole clock.
  task automatic pulse(input int n);
    @(posedge pclk);
    irq_line[n] <= 1'b1;
    @(posedge pclk);
    irq_line[n] <= 1'b0;
  endtask : pulse
  // Entry or return is a one-clock strobe; the idle id is inverted so it is never trusted.
  task automatic core(input logic ret, input int n);
    @(posedge pclk);
    isr_enter <= !ret;
    isr_return <= ret;
    isr_enter_id <= 6'(n);
    isr_return_id <= 6'(n);
    @(posedge pclk);
    isr_enter <= 1'b0;
    isr_return <= 1'b0;
    isr_enter_id <= ~6'(n);
    isr_return_id <= ~6'(n);
  endtask : core
  // External non-maskable line.
  task automatic nmi(input logic v);
    @(posedge pclk);
    nmi_pin <= v;
  endtask : nmi
endmodule : irq_peer_model

// ==== sim/nested_interrupt_pending_logic_bench.sv ====
// Self-checking bench of the interrupt controller.
`timescale 1ns/1ps
module nested_interrupt_pending_logic_bench
  import irq_ctrl_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, dv;
  logic pready, pslverr, er, nmi_pin, isr_enter, isr_return, req_valid, nmi_req, irq_out;
  logic [ID_W-1:0] isr_enter_id, isr_return_id, req_id;
  logic [PRIO_W-1:0] req_prio, req_group, req_sub;
  logic [35:0] irq_line, pending, active;
  logic [35:0] ep = '0;
  logic [35:0] ea = '0;
  int pr[36];
  int best;
  int seed = 32'hE243A64B;
  int bad_count = 0;
  int n_tests = 0;

  // Free-running bus clock.
  always #50 pclk = ~pclk;

  nested_vectored_irq_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq_line, .nmi_pin, .isr_enter, .isr_enter_id, .isr_return, .isr_return_id, .req_valid, .req_id,
    .req_prio, .req_group, .req_sub, .nmi_req, .pending, .active, .irq_out);
  irq_peer_model u_peer (.pclk, .irq_line, .nmi_pin, .isr_enter, .isr_enter_id, .isr_return, .isr_return_id);

  // Compares one value and counts the outcome.
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer, held until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Compares the state vectors with the bench model once settled.
  task automatic look();
    @(negedge pclk);
    chk(pending, ep);
    chk(active, ea);
  endtask : look

  // Prints the counts and the verdict.
  task automatic results();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  // Main sequence.
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    u_peer.level(3, 1'b1);
    ep[3] = 1'b1;
    look();
    @(negedge pclk);
    chk({req_valid, req_id}, {1'b1, 6'h03});
    u_peer.core(1'b0, 3);
    {ep[3], ea[3]} = 2'b01;
    look();
    u_peer.core(1'b1, 3);
    {ep[3], ea[3]} = 2'b10;
    look();
    u_peer.core(1'b0, 3);
    u_peer.level(3, 1'b0);
    u_peer.core(1'b1, 3);
    {ep[3], ea[3]} = 2'b00;
    look();
    u_peer.level(3, 1'b1);
    apb(1'b1, OFF_CLR_SET_PENDING_BANK_ZERO, 32'h8);
    ep[3] = 1'b1;
    look();
    u_peer.level(3, 1'b0);
    apb(1'b1, OFF_CLR_SET_PENDING_BANK_ZERO, 32'h8);
    ep[3] = 1'b0;
    look();
    apb(1'b1, OFF_MODE0, 32'h20);
    u_peer.pulse(5);
    ep[5] = 1'b1;
    look();
    u_peer.core(1'b0, 5);
    u_peer.pulse(5);
    ea[5] = 1'b1;
    look();
    apb(1'b1, OFF_CLR_SET_PENDING_BANK_ZERO, 32'h20);
    ep[5] = 1'b0;
    look();
    u_peer.pulse(5);
    u_peer.core(1'b1, 5);
    {ep[5], ea[5]} = 2'b10;
    look();
    apb(1'b1, OFF_CLR_SET_PENDING_BANK_ZERO, 32'h20);
    ep[5] = 1'b0;
    look();
    u_peer.pulse(5);
    u_peer.core(1'b0, 5);
    u_peer.core(1'b1, 5);
    look();
    apb(1'b1, OFF_SW_TRIG, 32'h21);
    apb(1'b1, OFF_SW_TRIG, 32'h24);
    apb(1'b1, OFF_SET_PEND1, 32'h4);
    ep[34:33] = 2'b11;
    look();
    apb(1'b0, OFF_SET_PEND1, 32'h0);
    chk(rd, 32'h6);
    apb(1'b1, OFF_SET_SET_PENDING_BANK_ZERO, 32'hFFFFFFFF);
    apb(1'b1, OFF_SET_PEND1, 32'hF);
    // Random priorities rewritten while every line is pending.
    for (int r = 0; r < 4; r++)
    begin
      for (int w = 0; w < 5; w++)
      begin
        dv = $random(seed);
        apb(1'b1, OFF_PRIO0 + 8'(4 * w), dv);
        for (int j = 0; j < 8 && 8 * w + j < 36; j++)
          pr[8 * w + j] = int'(dv[4 * j +: 3]);
      end
      apb(1'b1, OFF_GROUPING, 32'(r));
      best = 0;
      for (int i = 1; i < 36; i++)
        if (pr[i] < pr[best])
          best = i;
      @(posedge pclk);
      @(negedge pclk);
      chk({req_id, req_prio}, {6'(best), 3'(pr[best])});
      chk({req_group, req_sub}, {3'(pr[best] >> r), 3'(pr[best] % (1 << r))});
      apb(1'b0, OFF_REQ_STATUS, 32'h0);
      chk(rd, {5'h0, 3'(pr[best] % (1 << r)), 1'b0, 3'(pr[best] >> r), 1'b0, 3'(pr[best]), 2'h0, 6'(best), 7'h0, 1'b1});
    end
    apb(1'b1, OFF_CLR_SET_PENDING_BANK_ZERO, 32'hFFFFFFFF);
    apb(1'b1, OFF_CLR_PEND1, 32'hF);
    ep = '0;
    look();
    u_peer.nmi(1'b1);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk(nmi_req, 1'b1);
    apb(1'b0, OFF_INT_STATUS, 32'h0);
    chk({irq_out, rd}, 33'h3);
    apb(1'b1, OFF_INT_MASK, 32'h1);
    @(negedge pclk);
    chk(irq_out, 1'b1);
    apb(1'b1, OFF_INT_STATUS, 32'h1);
    @(negedge pclk);
    chk(irq_out, 1'b0);
    apb(1'b0, 8'h60, 32'h0);
    chk({er, rd}, 33'h100000000);
    results();
  end

  // Cuts a hang short.
  initial
  begin
    repeat (3000) @(posedge pclk);
    bad_count++;
    results();
  end
endmodule : nested_interrupt_pending_logic_bench

bind nested_vectored_irq_ctrl irq_ctrl_props #(.NUM_IRQ(NUM_IRQ)) u_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .irq_line, .nmi_pin, .isr_enter, .isr_enter_id, .isr_return, .isr_return_id, .req_valid, .req_id,
  .req_prio, .req_group, .req_sub, .nmi_req, .pending, .active);
